// *** core/cfc_top.v ***
`timescale 1ns/100ps
`default_nettype none
`include "cfc_consts.vh"
// Register map, one aligned word each:
//   0x000 control, bit 15 switches the module on.
//   0x004 flags, read-only; bits 1 and 0 mirror the pending levels.
//   0x008 filter control, odd slot in 15:8, even slot in 7:0.
//   0x00c mode, requested in 2:0 and current in 6:4.
//   0x010 time-stamp timer, sixteen bits, writable.
//   0x014 flag clear, write ones to clear sticky flags.
//   0x018 last route, valid in bit 5 and FIFO number in 4:0.
// Every other offset answers with an error and has no effect.
// The system-error flag ignores software clears on purpose.
module cfc_top
(
  input  wire        clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        wake_event,
  input  wire        bus_error_event,
  input  wire        system_error_event,
  input  wire        receive_overflow_event,
  input  wire        receive_pending,
  input  wire        transmit_pending,
  input  wire        even_hit,
  input  wire [1:0]  even_hit_mask,
  input  wire        odd_hit,
  input  wire [1:0]  odd_hit_mask,
  output reg         route_valid,
  output reg  [4:0]  route_fifo,
  output reg         module_on,
  output reg  [2:0]  current_operating_mode
);
  reg  [15:0] ctrl_q;
  reg  [2:0]  requested_operating_mode_q;
  reg  [15:0] timestamp_timer_q;
  reg         on_prev_q;
  reg         wake_flag_q;
  reg         berr_flag_q;
  reg         serr_flag_q;
  reg         rovf_flag_q;
  reg         mode_flag_q;
  reg         tmr_flag_q;
  reg         rxp_flag_q;
  reg         txp_flag_q;
  wire [15:0] flags_word;
  wire        access;
  wire        wr;
  wire        rd;
  wire        mapped;
  wire        hit_ctrl;
  wire        hit_flags;
  wire        hit_fltcon;
  wire        hit_mode;
  wire        hit_timer;
  wire        hit_clr;
  wire        hit_match;
  wire        wr_ctrl;
  wire        wr_mode;
  wire        wr_timer;
  wire        wr_fltcon;
  wire        wr_clr;
  wire [7:0]  even_ctrl;
  wire [7:0]  odd_ctrl;
  wire        even_route;
  wire        odd_route;
  wire [4:0]  even_fifo;
  wire [4:0]  odd_fifo;
  wire        on_cycle;
  wire        mode_done;
  wire        tmr_wrap;
  wire [15:0] clr_mask;

  // The access phase is a single cycle, so the slave never stretches it.
  assign access = psel && penable;
  assign wr     = access && pwrite;
  assign rd     = access && !pwrite;
  assign pready = 1'b1;

  // One decode line per register keeps the write strobes and the read path aligned.
  assign hit_ctrl   = (paddr == `CFC_ADDR_CTRL);
  assign hit_flags  = (paddr == `CFC_ADDR_FLAGS);
  assign hit_fltcon = (paddr == `CFC_ADDR_FLTCON);
  assign hit_mode   = (paddr == `CFC_ADDR_MODE);
  assign hit_timer  = (paddr == `CFC_ADDR_TIMER);
  assign hit_clr    = (paddr == `CFC_ADDR_FLAG_CLR);
  assign hit_match  = (paddr == `CFC_ADDR_MATCH);

  // Any other offset is answered with an error and changes nothing.
  assign mapped  = hit_ctrl || hit_flags || hit_fltcon || hit_mode ||
                   hit_timer || hit_clr || hit_match;
  assign pslverr = access && !mapped;

  // Write strobes; the flag register itself is read-only, so it has none.
  assign wr_ctrl   = wr && hit_ctrl;
  assign wr_mode   = wr && hit_mode;
  assign wr_timer  = wr && hit_timer;
  assign wr_fltcon = wr && hit_fltcon;
  assign wr_clr    = wr && hit_clr;

  // Module control register; only the enable bit has a meaning in this block.
  always @(posedge clk)
  begin
    if (!rst_n)
      ctrl_q <= `CFC_ZERO16;
    else if (wr_ctrl)
      ctrl_q <= pwdata[15:0];
  end

  // Previous enable, used to spot the off-to-on edge that clears the restricted flag.
  always @(posedge clk)
  begin
    if (!rst_n)
      on_prev_q <= 1'b0;
    else
      on_prev_q <= ctrl_q[`CFC_CTRL_ON];
  end

  // The enable bit is also shown on a pin for the rest of the controller.
  always @(posedge clk)
  begin
    if (!rst_n)
      module_on <= 1'b0;
    else
      module_on <= ctrl_q[`CFC_CTRL_ON];
  end

  // A rising enable after being off counts as one off/on cycle.
  assign on_cycle = ctrl_q[`CFC_CTRL_ON] && !on_prev_q;

  // Requested operating mode, set by software.
  always @(posedge clk)
  begin
    if (!rst_n)
      requested_operating_mode_q <= `CFC_MODE_RST;
    else if (wr_mode)
      requested_operating_mode_q <= pwdata[2:0];
  end

  // Current mode follows the request one clock later.
  always @(posedge clk)
  begin
    if (!rst_n)
      current_operating_mode <= `CFC_MODE_RST;
    else
      current_operating_mode <= requested_operating_mode_q;
  end

  // A difference now means the current mode is updated at the coming edge.
  assign mode_done = (current_operating_mode != requested_operating_mode_q);

  // Time-stamp timer runs while the module is on; a software write takes priority.
  always @(posedge clk)
  begin
    if (!rst_n)
      timestamp_timer_q <= `CFC_ZERO16;
    else if (wr_timer)
      timestamp_timer_q <= pwdata[15:0];
    else if (ctrl_q[`CFC_CTRL_ON])
      timestamp_timer_q <= timestamp_timer_q + `CFC_ONE16;
  end

  // The timer wraps at the edge after it reads all ones.
  assign tmr_wrap = ctrl_q[`CFC_CTRL_ON] && (timestamp_timer_q == `CFC_TMR_MAX);

  // Write-one-to-clear mask; the restricted flag never looks at it.
  assign clr_mask = wr_clr ? pwdata[15:0] : `CFC_ZERO16;

  // Wake-up activity flag; a new event wins over a clear in the same cycle.
  always @(posedge clk)
  begin
    if (!rst_n)
      wake_flag_q <= 1'b0;
    else
      wake_flag_q <= wake_event || (wake_flag_q && !clr_mask[`CFC_WAKE_BIT]);
  end

  // Bus error flag; a new event wins over a clear in the same cycle.
  always @(posedge clk)
  begin
    if (!rst_n)
      berr_flag_q <= 1'b0;
    else
      berr_flag_q <= bus_error_event || (berr_flag_q && !clr_mask[`CFC_BERR_BIT]);
  end

  // System error flag; only an off/on cycle of the module clears it.
  always @(posedge clk)
  begin
    if (!rst_n)
      serr_flag_q <= 1'b0;
    else
      serr_flag_q <= system_error_event || (serr_flag_q && !on_cycle);
  end

  // Receive overflow flag; a new event wins over a clear in the same cycle.
  always @(posedge clk)
  begin
    if (!rst_n)
      rovf_flag_q <= 1'b0;
    else
      rovf_flag_q <= receive_overflow_event || (rovf_flag_q && !clr_mask[`CFC_ROVF_BIT]);
  end

  // Mode change flag, raised as the current mode takes the requested value.
  always @(posedge clk)
  begin
    if (!rst_n)
      mode_flag_q <= 1'b0;
    else
      mode_flag_q <= mode_done || (mode_flag_q && !clr_mask[`CFC_MODE_BIT]);
  end

  // Timer overflow flag; a wrap wins over a clear in the same cycle.
  always @(posedge clk)
  begin
    if (!rst_n)
      tmr_flag_q <= 1'b0;
    else
      tmr_flag_q <= tmr_wrap || (tmr_flag_q && !clr_mask[`CFC_TMR_BIT]);
  end

  // Receive pending level, registered so that reads see a settled value.
  always @(posedge clk)
  begin
    if (!rst_n)
      rxp_flag_q <= 1'b0;
    else
      rxp_flag_q <= receive_pending;
  end

  // Transmit pending level, registered so that reads see a settled value.
  always @(posedge clk)
  begin
    if (!rst_n)
      txp_flag_q <= 1'b0;
    else
      txp_flag_q <= transmit_pending;
  end

  // Flag word; unimplemented bits read as zero.
  assign flags_word = {1'b0, wake_flag_q, berr_flag_q, serr_flag_q, rovf_flag_q, 7'h00,
                       mode_flag_q, tmr_flag_q, rxp_flag_q, txp_flag_q};

  // Even and odd filter slots of the filter control register.
  cfc_filter_slot u_even
  (
    .clk         (clk),
    .rst_n       (rst_n),
    .wr_en       (wr_fltcon),
    .wr_data     (pwdata[`CFC_EVEN_EN:`CFC_EVEN_FSEL_LO]),
    .hit         (even_hit),
    .hit_mask    (even_hit_mask),
    .ctrl        (even_ctrl),
    .route_valid (even_route),
    .route_fifo  (even_fifo)
  );

  cfc_filter_slot u_odd
  (
    .clk         (clk),
    .rst_n       (rst_n),
    .wr_en       (wr_fltcon),
    .wr_data     (pwdata[`CFC_ODD_EN:`CFC_ODD_FSEL_LO]),
    .hit         (odd_hit),
    .hit_mask    (odd_hit_mask),
    .ctrl        (odd_ctrl),
    .route_valid (odd_route),
    .route_fifo  (odd_fifo)
  );

  // Registered routing result; the lower-numbered filter wins.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      route_valid <= 1'b0;
      route_fifo  <= `CFC_ZERO5;
    end
    else
    begin
      route_valid <= even_route || odd_route;
      route_fifo  <= even_route ? even_fifo : odd_fifo;
    end
  end

  // Read multiplexer.
  always @*
  begin
    prdata = `CFC_ZERO32;
    if (rd)
    begin
      case (paddr)
        // Control word with the enable bit.
        `CFC_ADDR_CTRL:   prdata = {`CFC_ZERO16, ctrl_q};
        // Interrupt flags as one word.
        `CFC_ADDR_FLAGS:  prdata = {`CFC_ZERO16, flags_word};
        // Both filter slots, odd in the upper byte.
        `CFC_ADDR_FLTCON: prdata = {`CFC_ZERO16, odd_ctrl, even_ctrl};
        // Current and requested modes side by side.
        `CFC_ADDR_MODE:   prdata = {24'h000000, 1'b0, current_operating_mode, 1'b0, requested_operating_mode_q};
        // Running time-stamp value.
        `CFC_ADDR_TIMER:  prdata = {`CFC_ZERO16, timestamp_timer_q};
        // Last routing result.
        `CFC_ADDR_MATCH:  prdata = {26'h0000000, route_valid, route_fifo};
        // The clear register and unmapped offsets read as zero.
        default:          prdata = `CFC_ZERO32;
      endcase
    end
  end
endmodule // cfc_top
`default_nettype wire

// *** core/cfc_consts.vh ***
`ifndef CFC_CONSTS_VH
`define CFC_CONSTS_VH
// Register byte addresses.
`define CFC_ADDR_CTRL      12'h000
`define CFC_ADDR_FLAGS     12'h004
`define CFC_ADDR_FLTCON    12'h008
`define CFC_ADDR_MODE      12'h00c
`define CFC_ADDR_TIMER     12'h010
`define CFC_ADDR_FLAG_CLR  12'h014
`define CFC_ADDR_MATCH     12'h018
// Control register fields.
`define CFC_CTRL_ON        15
// Interrupt flag positions.
`define CFC_WAKE_BIT       14
`define CFC_BERR_BIT       13
`define CFC_SERR_BIT       12
`define CFC_ROVF_BIT       11
`define CFC_MODE_BIT       3
`define CFC_TMR_BIT        2
`define CFC_RXP_BIT        1
`define CFC_TXP_BIT        0
// Filter control fields.
`define CFC_ODD_EN         15
`define CFC_ODD_MSEL_HI    14
`define CFC_ODD_MSEL_LO    13
`define CFC_ODD_FSEL_HI    12
`define CFC_ODD_FSEL_LO    8
`define CFC_EVEN_EN        7
`define CFC_EVEN_MSEL_HI   6
`define CFC_EVEN_MSEL_LO   5
`define CFC_EVEN_FSEL_HI   4
`define CFC_EVEN_FSEL_LO   0
`define CFC_HALF_W         8
// Fields inside one eight-bit filter slot.
`define CFC_SLOT_EN        7
`define CFC_SLOT_MSEL_HI   6
`define CFC_SLOT_MSEL_LO   5
`define CFC_SLOT_FSEL_HI   4
`define CFC_SLOT_FSEL_LO   0
// Reset values and widths.
`define CFC_ZERO32         32'h00000000
`define CFC_ZERO16         16'h0000
`define CFC_ZERO8          8'h00
`define CFC_MODE_RST       3'h4
`define CFC_ONE16          16'h0001
`define CFC_ZERO5          5'h00
`define CFC_TMR_MAX        16'hffff
`endif

// *** core/cfc_filter_slot.v ***
`timescale 1ns/100ps
`default_nettype none
`include "cfc_consts.vh"
// One acceptance filter slot: all bits but enable write-protected while enabled, and match routing.
module cfc_filter_slot
(
  input  wire       clk,
  input  wire       rst_n,
  input  wire       wr_en,
  input  wire [7:0] wr_data,
  input  wire       hit,
  input  wire [1:0] hit_mask,
  output wire [7:0] ctrl,
  output wire       route_valid,
  output wire [4:0] route_fifo
);
  reg [7:0] ctrl_q;

  // The other control bits change only while enable is zero; the enable bit itself takes every write.
  always @(posedge clk)
  begin
    if (!rst_n)
      ctrl_q <= `CFC_ZERO8;
    else if (wr_en && !ctrl_q[`CFC_SLOT_EN])
      ctrl_q <= wr_data;
    else if (wr_en)
      ctrl_q[`CFC_SLOT_EN] <= wr_data[`CFC_SLOT_EN];
  end

  assign ctrl = ctrl_q;
  // A disabled filter never routes; the matcher must have used the chosen mask.
  assign route_valid = ctrl_q[`CFC_SLOT_EN] && hit &&
                       (hit_mask == ctrl_q[`CFC_SLOT_MSEL_HI:`CFC_SLOT_MSEL_LO]);
  assign route_fifo  = ctrl_q[`CFC_SLOT_FSEL_HI:`CFC_SLOT_FSEL_LO];
endmodule // cfc_filter_slot
`default_nettype wire

// *** tb/cfc_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
// Watches the register bus, the flag mirrors, the mode and the routing.
module cfc_asserts
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        receive_pending,
  input wire logic        transmit_pending,
  input wire logic        even_hit,
  input wire logic        odd_hit,
  input wire logic        route_valid,
  input wire logic        module_on,
  input wire logic [2:0]  current_operating_mode
);
  // All checks share the one clock and its reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic acc = psel && penable;
  ready_high_a: assert property (pready) else $error("pready low");
  unmapped_err_a: assert property (acc && paddr > 12'h018 |-> pslverr) else $error("no slverr");
  idle_zero_a: assert property (!acc |-> prdata == 32'h00000000) else $error("prdata not zero");
  rx_mirror_a: assert property (acc && !pwrite && paddr == 12'h004 |->
    prdata[1] == $past(receive_pending)) else $error("receive flag wrong");
  tx_mirror_a: assert property (acc && !pwrite && paddr == 12'h004 |->
    prdata[0] == $past(transmit_pending)) else $error("transmit flag wrong");
  enable_copy_a: assert property (acc && pwrite && paddr == 12'h000 |->
    ##2 module_on == $past(pwdata[15], 2)) else $error("module_on wrong");
  mode_follow_a: assert property (acc && pwrite && paddr == 12'h00c |->
    ##2 current_operating_mode == $past(pwdata[2:0], 2)) else $error("mode not followed");
  route_cause_a: assert property (route_valid |-> $past(even_hit || odd_hit)) else $error("route without hit");
endmodule // cfc_asserts
bind cfc_top cfc_asserts chk_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .receive_pending(receive_pending), .transmit_pending(transmit_pending), .even_hit(even_hit),
  .odd_hit(odd_hit), .route_valid(route_valid), .module_on(module_on),
  .current_operating_mode(current_operating_mode));
`default_nettype wire

// *** tb/cfc_can_node.sv ***
`timescale 1ns/100ps
`default_nettype none
// Stands in for the other bus nodes: each command bit is copied to its event one cycle later.
module cfc_can_node
(
  input  wire logic       clk,
  input  wire logic [3:0] fire,
  output var  logic [3:0] events
);
  // Pulses start quiet and change just after a rising edge.
  initial events = 4'h0;
  always @(posedge clk)
  begin
    events <= fire;
  end
endmodule // cfc_can_node
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
// Drives the block over APB and its event and hit inputs, then checks reads and routes.
module tb_top;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, ehit = 0, ohit = 0, rxp = 0, txp = 0;
  logic        pready, pslverr, rv, mo;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rs = 32'h9e59, v;
  logic [32:0] pd, rdq[$], rtq[$];
  logic [3:0]  fire = 0, ev;
  logic [1:0]  ehm = 0, ohm = 0;
  logic [4:0]  rf;
  logic [2:0]  com;
  int          bad_count = 0, comparisons = 0;
  always #25 clk = ~clk;
  cfc_can_node node_u (.clk(clk), .fire(fire), .events(ev));
  cfc_top dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .wake_event(ev[3]),
    .bus_error_event(ev[2]), .system_error_event(ev[1]), .receive_overflow_event(ev[0]),
    .receive_pending(rxp), .transmit_pending(txp), .even_hit(ehit), .even_hit_mask(ehm), .odd_hit(ohit),
    .odd_hit_mask(ohm), .route_valid(rv), .route_fifo(rf), .module_on(mo), .current_operating_mode(com));
  // Fixed-seed xorshift source.
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Route results are widened and passed to the common compare, so their mismatches print the same message.
  task automatic cmp_route(input logic [4:0] got, input logic [32:0] exp);
    cmp({28'h0, got}, exp);
  endtask
  // One APB transfer, held until pready is seen high, then an idle edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    for (n = 0; n < 9; n++)
    begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 9)
    begin
      bad_count++;
      tally_and_finish();
    end
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    rdq.push_back(e);
    apb(0, a, 32'h0);
  endtask
  // Both matchers report a hit with mask mk for one cycle.
  task automatic hit(input logic [1:0] mk);
    ehit <= 1;
    ohit <= 1;
    ehm <= mk;
    ohm <= mk;
    @(posedge clk);
    ehit <= 0;
    ohit <= 0;
    repeat (2) @(posedge clk);
  endtask
  // Read data with its error bit, taken at the edge that ends the access.
  always @(posedge clk)
  begin
    if (psel && penable && !pwrite && pready === 1'b1)
      cmp({pslverr, prdata}, rdq.pop_front());
  end
  // Every route seen must have been noted; an unnoted one always mismatches.
  always @(negedge clk)
  begin
    if (rv === 1'b1)
      cmp_route(rf, rtq.size() ? rtq.pop_front() : 33'h1ffffffff);
  end
  initial
  begin
    rs = xs(rs);
    rxp = rs[0];
    txp = rs[1];
    pd = {31'h0, rs[0], rs[1]};
    repeat (12) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    rd(12'h004, pd);
    rd(12'h00c, 33'h44);
    rd(12'h100, 33'h100000000);
    fire <= 4'hf;
    @(posedge clk);
    fire <= 4'h0;
    apb(1, 12'h004, 32'hffffffff);
    rd(12'h004, pd | 33'h7800);
    apb(1, 12'h014, 32'hffffffff);
    rd(12'h004, pd | 33'h1000);
    apb(1, 12'h000, 32'h0);
    apb(1, 12'h000, 32'h8000);
    apb(1, 12'h010, 32'hfff8);
    apb(1, 12'h00c, 32'h1);
    repeat (20) @(posedge clk);
    rd(12'h004, pd | 33'hc);
    rd(12'h00c, 33'h11);
    rs = xs(rs);
    v = rs & 32'h7f7f;
    apb(1, 12'h008, v);
    apb(1, 12'h008, v | 32'h8080);
    apb(1, 12'h008, ~rs | 32'h8080);
    rd(12'h008, {1'b0, v | 32'h8080});
    for (int i = 0; i < 4; i++)
    begin
      rs = xs(rs);
      apb(1, 12'h008, 32'h0);
      apb(1, 12'h008, {16'h0, 1'b1, i[1:0], rs[4:0], i[0], i[1:0], rs[12:8]});
      rtq.push_back({28'h0, i[0] ? rs[12:8] : rs[4:0]});
      hit(i[1:0]);
      hit(~i[1:0]);
    end
    cmp(33'(rtq.size()), 33'h0);
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
